// ---- fsto_debounce.sv ----
// package of shared constants and types, and the single-input debounce filter
package fsto_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS = 1000000;
  localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;
  localparam int TIME_W = 16;
  localparam int UPSTREAM_ON_TEST_MS = 1;
  localparam int UPSTREAM_OFF_TEST_MS = 4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_DISC_TIME = 8'h08;
  localparam logic [7:0] OFS_SAFE_DEB = 8'h0C;
  localparam logic [7:0] OFS_STD_DEB = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_FAULT = 8'h1C;
  localparam logic [7:0] OFS_TOG_LIMIT = 8'h20;

  // ==========================================================
  // field positions
  localparam int ST_SELECTED_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_TEST_DUE_BIT = 31;
  localparam int CTRL_CLEAR_BIT = 8;
  localparam int IRQ_DISC_BIT = 0;
  localparam int IRQ_TOG_BIT = 1;
  localparam int IRQ_SEL_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int FLT_DISC_BIT = 0;
  localparam int FLT_TOG_BIT = 1;
  localparam int FLT_CH_A_BIT = 4;
  localparam int FLT_CH_B_BIT = 5;
  localparam int STD_N = 4;

  // ==========================================================
  // reset values and the fixed toggle window length
  localparam logic [15:0] DISC_TIME_RST = 16'h01F4;
  localparam logic [15:0] SAFE_DEB_RST = 16'h0001;
  localparam logic [15:0] STD_DEB_RST = 16'h0003;
  localparam logic [7:0] TOG_LIMIT_RST = 8'h10;
  localparam logic [15:0] TOG_WINDOW_MS = 16'h03E8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SRC_TERMINALS = 2'h0,
    SRC_FIELDBUS = 2'h1,
    SRC_COMBINED = 2'h3
  } fsto_src_t;

  typedef struct packed {
    logic level;
    logic [MS_CNT_W-1:0] sub;
    logic [TIME_W-1:0] ms;
  } fsto_deb_t;

  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] gate_off;
    logic [1:0] test_due;
    logic [STD_N-1:0] std1;
    logic [STD_N-1:0] std2;
  } fsto_sync_t;

  typedef struct packed {
    fsto_sync_t sync;
    fsto_src_t mode;
    logic [TIME_W-1:0] disc_time;
    logic [TIME_W-1:0] safe_deb;
    logic [TIME_W-1:0] std_deb;
    logic [7:0] tog_limit;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic disc_fault;
    logic tog_fault;
    logic [MS_CNT_W-1:0] pre;
    logic [MS_CNT_W-1:0] disc_sub;
    logic [TIME_W-1:0] disc_ms;
    logic [TIME_W-1:0] win_ms;
    logic [7:0] tog_cnt;
    logic prev_a;
    logic prev_b;
    logic selected;
    logic active;
    logic gate_en;
    logic test_due;
    logic irq;
    logic [31:0] rdata;
  } fsto_state_t;

endpackage

`timescale 1ns/1ps
`default_nettype none

module fsto_debounce #(
  parameter int CYC_PER_MS = fsto_pkg::CYC_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in,
  input wire logic [fsto_pkg::TIME_W-1:0] i_time_ms,
  output logic o_out
);

  fsto_pkg::fsto_deb_t s_q;
  fsto_pkg::fsto_deb_t s_d;

  // ==========================================================
  // the output follows only after the input has held i_time_ms full milliseconds
  always_comb begin
    s_d = s_q;
    if (i_in == s_q.level) begin
      s_d.sub = '0;
      s_d.ms = '0;
    end else if (i_time_ms == '0 ||
                 // a setting lowered in mid-count still ends the count
                 (s_q.ms >= i_time_ms - 16'h0001 &&
                  s_q.sub == fsto_pkg::MS_CNT_W'(CYC_PER_MS - 1))) begin
      s_d.level = i_in;
      s_d.sub = '0;
      s_d.ms = '0;
    end else if (s_q.sub == fsto_pkg::MS_CNT_W'(CYC_PER_MS - 1)) begin
      s_d.sub = '0;
      s_d.ms = s_q.ms + 16'h0001;
    end else begin
      s_d.sub = s_q.sub + 17'h00001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_out = s_q.level;

endmodule

`default_nettype wire

// ---- fsto_core.sv ----
// fail-safe input pair evaluation: discrepancy, debounce, toggle watch, torque cutoff status
// How it works
// - compare both channels continuously for discrepancy
// - tolerate discrepancy up to programmable time
// - persisting discrepancy beyond tolerance raises fault
// - with terminals in use, any channel falling selects cutoff immediately (here only after the two-stage synchroniser and the safety debounce time)
// - debounce channels, drop pulses shorter than setting
// - debounce adds exactly its time to response
// - too many changes per interval raises fault
// - status bit 0 shows cutoff selected
// - status bit 1 shows cutoff really active
// - status bit 31 shows test stop due
// - standard and safety debounce settings independent
// - control source: terminals, fieldbus, or combined
// - while active, no torque energy to motor
`timescale 1ns/1ps
`default_nettype none

module fsto_core #(
  parameter int CYC_PER_MS = fsto_pkg::CYC_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ch_a,
  input wire logic i_ch_b,
  input wire logic i_bus_cutoff,
  input wire logic i_gate_off,
  input wire logic i_test_stop_due,
  input wire logic [fsto_pkg::STD_N-1:0] i_std_in,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_cutoff_selected,
  output logic o_cutoff_active,
  output logic o_gate_enable,
  output logic o_test_stop_due,
  output logic [fsto_pkg::STD_N-1:0] o_std_in
);

  fsto_pkg::fsto_state_t s_q;
  fsto_pkg::fsto_state_t s_d;

  logic filt_a;
  logic filt_b;
  logic [fsto_pkg::STD_N-1:0] std_filt;

  // ==========================================================
  // helpers
  // last cycle of a millisecond for a sub-millisecond count
  function automatic logic ms_last(input logic [fsto_pkg::MS_CNT_W-1:0] cnt);
    return cnt == fsto_pkg::MS_CNT_W'(CYC_PER_MS - 1);
  endfunction

  // rising edge of a latched condition, for the sticky event bits
  function automatic logic went_high(input logic was, input logic cur);
    return cur && !was;
  endfunction

  // change count that stops at its top value instead of wrapping
  function automatic logic [7:0] sat_inc(input logic [7:0] cnt);
    return (cnt == 8'hFF) ? cnt : cnt + 8'h01;
  endfunction

  // ==========================================================
  // safety channel filters, using the safety debounce time only
  // both share one setting, so A and B see an equal delay
  fsto_debounce #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_deb_a (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in(s_q.sync.a[1]),
    .i_time_ms(s_q.safe_deb),
    .o_out(filt_a)
  );

  fsto_debounce #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_deb_b (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in(s_q.sync.b[1]),
    .i_time_ms(s_q.safe_deb),
    .o_out(filt_b)
  );

  // ==========================================================
  // standard inputs, filtered by their own setting
  // their setting never reaches the safety filters, nor the reverse
  for (genvar g = 0; g < fsto_pkg::STD_N; g++) begin : g_std
    fsto_debounce #(
      .CYC_PER_MS(CYC_PER_MS)
    ) u_deb_std (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_in(s_q.sync.std2[g]),
      .i_time_ms(s_q.std_deb),
      .o_out(std_filt[g])
    );
  end

  // ==========================================================
  // next-state logic
  logic ms_tick;
  logic disagree;
  logic changed;
  logic term_sel;
  logic src_sel;
  logic clear_req;
  logic disc_hit;
  logic tog_hit;
  logic rd_stat;
  logic [31:0] rd_val;

  always_comb begin
    s_d = s_q;
    ms_tick = 1'b0;
    disagree = 1'b0;
    changed = 1'b0;
    term_sel = 1'b0;
    src_sel = 1'b0;
    clear_req = 1'b0;
    disc_hit = 1'b0;
    tog_hit = 1'b0;
    rd_stat = 1'b0;
    rd_val = 32'h00000000;

    // two-stage synchronisers for every pin except i_bus_cutoff and the register port
    // the first flop of a pair feeds nothing but the second
    s_d.sync.a = {s_q.sync.a[0], i_ch_a};
    s_d.sync.b = {s_q.sync.b[0], i_ch_b};
    s_d.sync.gate_off = {s_q.sync.gate_off[0], i_gate_off};
    s_d.sync.test_due = {s_q.sync.test_due[0], i_test_stop_due};
    s_d.sync.std1 = i_std_in;
    s_d.sync.std2 = s_q.sync.std1;

    // millisecond prescaler for the toggle window
    if (ms_last(s_q.pre)) begin
      s_d.pre = '0;
      ms_tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 17'h00001;
    end

    // discrepancy timer, one unbroken interval only
    disagree = filt_a ^ filt_b;
    if (!disagree) begin
      s_d.disc_sub = '0;
      s_d.disc_ms = '0;
    end else begin
      // the timer halts at the tolerance, so the fault is reasserted each cycle
      if (s_q.disc_ms >= s_q.disc_time) begin
        disc_hit = 1'b1;
      end else if (ms_last(s_q.disc_sub)) begin
        s_d.disc_sub = '0;
        s_d.disc_ms = s_q.disc_ms + 16'h0001;
      end else begin
        s_d.disc_sub = s_q.disc_sub + 17'h00001;
      end
    end

    // change counter over a fixed monitoring window
    // the window runs freely from reset, not from the first change
    s_d.prev_a = filt_a;
    s_d.prev_b = filt_b;
    changed = (filt_a != s_q.prev_a) || (filt_b != s_q.prev_b);
    if (ms_tick && s_q.win_ms == fsto_pkg::TOG_WINDOW_MS - 16'h0001) begin
      s_d.win_ms = '0;
      s_d.tog_cnt = '0;
    end else begin
      if (ms_tick) begin
        s_d.win_ms = s_q.win_ms + 16'h0001;
      end
      if (changed) begin
        s_d.tog_cnt = sat_inc(s_q.tog_cnt);
      end
    end
    tog_hit = (s_q.tog_cnt > s_q.tog_limit);

    // register writes
    if (i_wr) begin
      case (i_addr)
        fsto_pkg::OFS_CTRL: begin
          s_d.mode = fsto_pkg::fsto_src_t'(i_wdata[1:0]);
          clear_req = i_wdata[fsto_pkg::CTRL_CLEAR_BIT];
        end
        fsto_pkg::OFS_DISC_TIME: begin
          s_d.disc_time = i_wdata[15:0];
        end
        fsto_pkg::OFS_SAFE_DEB: begin
          s_d.safe_deb = i_wdata[15:0];
        end
        fsto_pkg::OFS_STD_DEB: begin
          s_d.std_deb = i_wdata[15:0];
        end
        fsto_pkg::OFS_IRQ_MASK: begin
          s_d.irq_mask = i_wdata[fsto_pkg::IRQ_W-1:0];
        end
        fsto_pkg::OFS_TOG_LIMIT: begin
          s_d.tog_limit = i_wdata[7:0];
        end
        default: begin
          // read-only and unmapped offsets fall through and are lost
        end
      endcase
    end

    // faults latch; a clear of the discrepancy fault only succeeds once the cause has gone
    if (clear_req) begin
      s_d.disc_fault = 1'b0;
      s_d.tog_fault = 1'b0;
      s_d.tog_cnt = '0;
    end
    if (disc_hit) begin
      s_d.disc_fault = 1'b1;
    end
    // the clear also empties the change count, so here the clear wins;
    // a set winning would re-latch from a count that is already gone
    if (tog_hit && !clear_req) begin
      s_d.tog_fault = 1'b1;
    end

    // torque cutoff selection by control source
    term_sel = !(filt_a && filt_b);
    // code 2 is no defined source and behaves as terminals only
    case (s_q.mode)
      fsto_pkg::SRC_FIELDBUS: begin
        src_sel = i_bus_cutoff;
      end
      fsto_pkg::SRC_COMBINED: begin
        src_sel = term_sel || i_bus_cutoff;
      end
      default: begin
        src_sel = term_sel;
      end
    endcase
    // faults force the cutoff in every source mode
    s_d.selected = src_sel || s_d.disc_fault || s_d.tog_fault;
    s_d.gate_en = !s_d.selected;
    // active also needs the power stage's own off feedback
    s_d.active = s_q.selected && !s_q.gate_en && s_q.sync.gate_off[1];
    s_d.test_due = s_q.sync.test_due[1];

    // register reads, data one cycle after the strobe
    case (i_addr)
      fsto_pkg::OFS_STATUS: begin
        rd_val[fsto_pkg::ST_SELECTED_BIT] = s_q.selected;
        rd_val[fsto_pkg::ST_ACTIVE_BIT] = s_q.active;
        rd_val[fsto_pkg::ST_TEST_DUE_BIT] = s_q.test_due;
      end
      fsto_pkg::OFS_CTRL: begin
        rd_val[1:0] = s_q.mode;
      end
      fsto_pkg::OFS_DISC_TIME: begin
        rd_val[15:0] = s_q.disc_time;
      end
      fsto_pkg::OFS_SAFE_DEB: begin
        rd_val[15:0] = s_q.safe_deb;
      end
      fsto_pkg::OFS_STD_DEB: begin
        rd_val[15:0] = s_q.std_deb;
      end
      fsto_pkg::OFS_IRQ_STAT: begin
        rd_val[fsto_pkg::IRQ_W-1:0] = s_q.irq_stat;
        // a read of the event bits is also their clear
        rd_stat = i_rd;
      end
      fsto_pkg::OFS_IRQ_MASK: begin
        rd_val[fsto_pkg::IRQ_W-1:0] = s_q.irq_mask;
      end
      fsto_pkg::OFS_FAULT: begin
        rd_val[fsto_pkg::FLT_DISC_BIT] = s_q.disc_fault;
        rd_val[fsto_pkg::FLT_TOG_BIT] = s_q.tog_fault;
        rd_val[fsto_pkg::FLT_CH_A_BIT] = filt_a;
        rd_val[fsto_pkg::FLT_CH_B_BIT] = filt_b;
      end
      fsto_pkg::OFS_TOG_LIMIT: begin
        rd_val[7:0] = s_q.tog_limit;
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
    s_d.rdata = i_rd ? rd_val : 32'h00000000;

    // sticky events, a read clears them but a new event wins
    if (rd_stat) begin
      s_d.irq_stat = '0;
    end
    if (went_high(s_q.disc_fault, s_d.disc_fault)) begin
      s_d.irq_stat[fsto_pkg::IRQ_DISC_BIT] = 1'b1;
    end
    if (went_high(s_q.tog_fault, s_d.tog_fault)) begin
      s_d.irq_stat[fsto_pkg::IRQ_TOG_BIT] = 1'b1;
    end
    if (went_high(s_q.selected, s_d.selected)) begin
      s_d.irq_stat[fsto_pkg::IRQ_SEL_BIT] = 1'b1;
    end
    // the mask gates only the line; the status bits still record
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ==========================================================
  // state register
  // settings come up at their defaults and the cutoff comes up selected
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.mode <= fsto_pkg::SRC_TERMINALS;
      s_q.disc_time <= fsto_pkg::DISC_TIME_RST;
      s_q.safe_deb <= fsto_pkg::SAFE_DEB_RST;
      s_q.std_deb <= fsto_pkg::STD_DEB_RST;
      s_q.tog_limit <= fsto_pkg::TOG_LIMIT_RST;
      s_q.selected <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // every output is a flop of the state or of a filter
  assign o_rdata = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_cutoff_selected = s_q.selected;
  assign o_cutoff_active = s_q.active;
  assign o_gate_enable = s_q.gate_en;
  assign o_test_stop_due = s_q.test_due;
  assign o_std_in = std_filt;

endmodule

`default_nettype wire

// ---- fsto_core_sva.sv ----
// port assertions for the fail-safe input pair block
`timescale 1ns/1ps
`default_nettype none
module fsto_core_sva (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_gate_off,
  input wire logic i_test_stop_due,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_cutoff_selected,
  input wire logic o_cutoff_active,
  input wire logic o_gate_enable,
  input wire logic o_test_stop_due
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_status_read;
    $past(i_rd) && $past(i_addr) == fsto_pkg::OFS_STATUS;
  endsequence
  sequence s_off_confirmed;
    (o_cutoff_selected && i_gate_off)[*4];
  endsequence
  // ==========================================================
  // assertions
  a_gate_follows_sel: assert property (o_gate_enable == !o_cutoff_selected)
    else $error("gate enable not inverse of cutoff selected");
  a_active_needs_sel: assert property (o_cutoff_active |->
    o_cutoff_selected || $past(o_cutoff_selected))
    else $error("active without selection");
  a_active_rise: assert property ($rose(o_cutoff_active) |->
    $past(o_cutoff_selected))
    else $error("active rose while not selected");
  a_active_confirm: assert property (s_off_confirmed |=> o_cutoff_active)
    else $error("active missing after gate off feedback");
  a_status_sel: assert property (s_status_read ##0 $stable(o_cutoff_selected) |->
    o_rdata[0] == o_cutoff_selected)
    else $error("status bit 0 differs from selected");
  a_status_test: assert property (s_status_read ##0 $stable(o_test_stop_due) |->
    o_rdata[31] == o_test_stop_due)
    else $error("status bit 31 differs from test due");
  a_test_follow: assert property (i_test_stop_due [*4] |=> o_test_stop_due)
    else $error("test due not reported");
  a_test_clear: assert property ((!i_test_stop_due) [*4] |=> !o_test_stop_due)
    else $error("test due stuck high");
  a_sel_after_reset: assert property ($fell(i_reset) |-> o_cutoff_selected [*3])
    else $error("cutoff released too early after reset");
endmodule
bind fsto_core fsto_core_sva u_sva (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_gate_off(i_gate_off),
  .i_test_stop_due(i_test_stop_due),
  .i_addr(i_addr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_cutoff_selected(o_cutoff_selected),
  .o_cutoff_active(o_cutoff_active),
  .o_gate_enable(o_gate_enable),
  .o_test_stop_due(o_test_stop_due)
);
`default_nettype wire

// ---- fsto_field.sv ----
// model of the sensor pair, power stage feedback and test timer
`timescale 1ns/1ps
`default_nettype none
module fsto_field (
  input wire logic i_clk,
  input wire logic i_gate_enable,
  output logic o_ch_a,
  output logic o_ch_b,
  output logic o_gate_off,
  output logic o_test_due
);
  logic [1:0] gate_q;
  initial begin
    o_ch_a = 1'b0;
    o_ch_b = 1'b0;
    o_gate_off = 1'b0;
    o_test_due = 1'b0;
    gate_q = 2'b00;
  end
  // power stage confirms off a few cycles after the enable drops
  always @(posedge i_clk) begin
    gate_q <= {gate_q[0], ~i_gate_enable};
    o_gate_off <= gate_q[1];
  end
  task automatic set_pair(input logic a, input logic b);
    @(posedge i_clk);
    o_ch_a <= a;
    o_ch_b <= b;
  endtask
  // short dark pulse on one channel, as a test pattern or bounce
  task automatic pulse_a(input int len);
    @(posedge i_clk);
    o_ch_a <= 1'b0;
    repeat (len) @(posedge i_clk);
    o_ch_a <= 1'b1;
  endtask
  task automatic set_due(input logic v);
    @(posedge i_clk);
    o_test_due <= v;
  endtask
endmodule
`default_nettype wire

// ---- fsto_core_bench.sv ----
// self-checking bench for the fail-safe input pair block
`timescale 1ns/1ps
`default_nettype none
module fsto_core_bench;
  logic i_clk, i_reset, i_bus_cutoff, i_wr, i_rd, ch_a, ch_b, gate_off, test_due;
  logic [fsto_pkg::STD_N-1:0] i_std_in, o_std_in;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic o_irq, o_cutoff_selected, o_cutoff_active, o_gate_enable, o_test_stop_due, sel;
  int n_fail, cmp_count, cycles, n;
  int modes[4] = '{0, 1, 2, 3};
  logic [39:0] rst_tab[6] = '{{8'h08, 32'h1F4}, {8'h0C, 32'h1}, {8'h10, 32'h3},
    {8'h18, 32'h0}, {8'h20, 32'h10}, {8'h3C, 32'h0}};
  fsto_core #(.CYC_PER_MS(10)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ch_a(ch_a),
    .i_ch_b(ch_b), .i_bus_cutoff(i_bus_cutoff), .i_gate_off(gate_off),
    .i_test_stop_due(test_due), .i_std_in(i_std_in), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_cutoff_selected(o_cutoff_selected), .o_cutoff_active(o_cutoff_active),
    .o_gate_enable(o_gate_enable), .o_test_stop_due(o_test_stop_due), .o_std_in(o_std_in));
  fsto_field i_far (.i_clk(i_clk), .i_gate_enable(o_gate_enable), .o_ch_a(ch_a),
    .o_ch_b(ch_b), .o_gate_off(gate_off), .o_test_due(test_due));
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and timeout
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  // ==========================================================
  // tests
  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_bus_cutoff = 1'b0;
    i_std_in = 4'h0;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rst_tab[k]) begin
      rd(rst_tab[k][39:32], rv);
      check(rv, rst_tab[k][31:0]);
    end
    $display("reset values done");
    wr(fsto_pkg::OFS_DISC_TIME, 32'h3);
    wr(fsto_pkg::OFS_TOG_LIMIT, 32'hFF);
    i_far.set_pair(1'b1, 1'b1);
    cyc(30);
    rd(fsto_pkg::OFS_IRQ_STAT, rv);
    check(32'(o_gate_enable), 32'h1);
    i_far.set_pair(1'b0, 1'b1);
    n = 0;
    while (o_cutoff_selected !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n, 13);
    check(32'(o_gate_enable), 32'h0);
    i_far.set_pair(1'b1, 1'b1);
    cyc(20);
    i_far.pulse_a(5);
    n = 0;
    repeat (30) begin
      cyc(1);
      if (o_cutoff_selected !== 1'b0) n++;
    end
    check(n, 0);
    $display("selection and filter done");
    repeat (2) begin
      i_far.set_pair(1'b0, 1'b1);
      cyc(20);
      i_far.set_pair(1'b1, 1'b1);
      cyc(20);
    end
    rd(fsto_pkg::OFS_FAULT, rv);
    check(32'(rv[1:0]), 32'h0);
    i_far.set_pair(1'b0, 1'b1);
    cyc(60);
    rd(fsto_pkg::OFS_FAULT, rv);
    check(32'(rv[1:0]), 32'h1);
    i_far.set_pair(1'b1, 1'b1);
    cyc(30);
    check(32'(o_cutoff_selected), 32'h1);
    wr(fsto_pkg::OFS_CTRL, 32'h100);
    cyc(5);
    check(32'(o_cutoff_selected), 32'h0);
    rd(fsto_pkg::OFS_FAULT, rv);
    check(rv, 32'h30);
    rd(fsto_pkg::OFS_IRQ_STAT, rv);
    check(rv, 32'h5);
    rd(fsto_pkg::OFS_IRQ_STAT, rv);
    check(rv, 32'h0);
    wr(fsto_pkg::OFS_IRQ_MASK, 32'h4);
    i_far.set_pair(1'b0, 1'b0);
    cyc(20);
    check(32'(o_irq), 32'h1);
    rd(fsto_pkg::OFS_IRQ_STAT, rv);
    check(rv, 32'h4);
    cyc(2);
    check(32'(o_irq), 32'h0);
    $display("discrepancy and interrupt done");
    foreach (modes[k]) begin
      for (int b = 0; b < 2; b++) begin
        for (int a = 0; a < 2; a++) begin
          wr(fsto_pkg::OFS_CTRL, 32'(modes[k]));
          i_bus_cutoff <= b[0];
          i_far.set_pair(a[0], a[0]);
          cyc(30);
          // fieldbus only, combined, and terminals for codes 0 and 2
          sel = (modes[k] == 1) ? b[0] : (modes[k] == 3) ? (b[0] | !a[0]) : !a[0];
          rd(fsto_pkg::OFS_STATUS, rv);
          check(32'(rv[1:0]), {30'h0, sel, sel});
        end
      end
    end
    wr(fsto_pkg::OFS_CTRL, 32'h0);
    $display("control sources done");
    i_far.set_due(1'b1);
    cyc(6);
    rd(fsto_pkg::OFS_STATUS, rv);
    check(32'(rv[31]), 32'h1);
    i_far.set_due(1'b0);
    wr(fsto_pkg::OFS_STD_DEB, 32'h0);
    i_std_in <= 4'hA;
    cyc(6);
    check(32'(o_std_in), 32'hA);
    rd(fsto_pkg::OFS_SAFE_DEB, rv);
    check(rv, 32'h1);
    wr(fsto_pkg::OFS_SAFE_DEB, 32'h0);
    wr(fsto_pkg::OFS_TOG_LIMIT, 32'h2);
    wr(fsto_pkg::OFS_CTRL, 32'h100);
    repeat (3) begin
      i_far.set_pair(1'b0, 1'b0);
      cyc(4);
      i_far.set_pair(1'b1, 1'b1);
      cyc(4);
    end
    rd(fsto_pkg::OFS_FAULT, rv);
    check(32'(rv[1]), 32'h1);
    $display("test stop, inputs and toggle done");
    results();
  end
endmodule
`default_nettype wire
